// ---- hw/startup_seq_defs.vh ----
`ifndef STARTUP_SEQ_DEFS_VH
`define STARTUP_SEQ_DEFS_VH

////////////////////////////////////////////////////////////////////////
// timing
`define CORE_CLK_MHZ 200
`define OSC_FREQ_MHZ 16
// half period of the internal oscillator in core cycles, rounded down
`define OSC_HALF_CYC (`CORE_CLK_MHZ / (2 * `OSC_FREQ_MHZ))
`define RB_WORDS_DEFAULT 16

////////////////////////////////////////////////////////////////////////
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_RB_CMD 8'h08
`define OFF_EFFECTIVE 8'h0C

////////////////////////////////////////////////////////////////////////
// control register fields
`define CTRL_CLKSEL 0
`define CTRL_SYNC 1
`define CTRL_LCMETH 2
`define CTRL_OSCSEL 3
`define CTRL_RBABORT 4
`define CTRL_RBEN 5
`define CTRL_GSR_LO 8
`define CTRL_OUT_LO 12
`define CTRL_WMASK 32'h0000_FF3F
// set/reset release C3, output release C2, all options off
`define CTRL_RESET 32'h0000_1200

// readback command bits
`define RB_START 0
`define RB_ABORT 1

////////////////////////////////////////////////////////////////////////
// startup event codes
`define EV_C2 4'h1
`define EV_C3 4'h2
`define EV_C4 4'h3
`define EV_U2 4'h4
`define EV_U3 4'h5
`define EV_U4 4'h6
`define EV_DI 4'h7
`define EV_DI1 4'h8
`define EV_DI2 4'h9
`define EV_GSR_DEFAULT 4'h2
`define EV_OUT_DEFAULT 4'h1

`endif

// ---- hw/pin_sampler.v ----
`timescale 1ns/1ps
module pin_sampler #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // raw pins
  input wire [WIDTH-1:0] pin_in,
  // sampled level and rising-edge pulse
  output wire [WIDTH-1:0] level_out,
  output wire [WIDTH-1:0] rise_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      reg meta_ff;
      reg sync_ff;
      reg last_ff;
      // two flops first; only the second one is looked at
      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          last_ff <= 1'b0;
        end else begin
          meta_ff <= pin_in[i];
          sync_ff <= meta_ff;
          last_ff <= sync_ff;
        end
      end
      assign level_out[i] = sync_ff;
      assign rise_out[i] = sync_ff & ~last_ff;
    end
  endgenerate

endmodule

// ---- hw/startup_sequencer.v ----
// Notes on behaviour
// (RULE1) set/reset released on chosen event, default C3
// (RULE2) C2..C4 count config clock edges after count
// (RULE3) U2..U4 count user edges after first config edge
// (RULE4) done events: done high, then one, two edges
// (RULE5) set/reset event limited per clock and sync
// (RULE6) outputs held until chosen event, default C2
// (RULE7) output event limited by same four combinations
// (RULE8) offered events depend on clock and sync
// (RULE9) length count method selectable, length default
// (RULE10) oscillator from internal or user clock
// (RULE11) readback abort only when enabled, default off
// (RULE12) readback only when enabled, default off
// (RULE13) startup clocked by config or user clock
// (RULE14) with sync, startup waits on external done; here only DI, DI1 or DI2 choices wait, C2, C3 and U2 stay offered
// (RULE15) disallowed event choice falls back to default; here U2 when the default is not offered
`timescale 1ns/1ps
`include "startup_seq_defs.vh"
module startup_sequencer #(
  parameter ADDR_W = 8,
  parameter RB_WORDS = `RB_WORDS_DEFAULT
) (
  // clock and reset
  input wire CORE_CLK_IN,
  input wire RST_N_IN,
  // apb slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [ADDR_W-1:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output wire [31:0] PRDATA_OUT,
  output wire PREADY_OUT,
  output wire PSLVERR_OUT,
  // configuration side, same clock domain
  input wire LENGTH_COUNT_MET_IN,
  // pins from outside the core clock domain
  input wire CONFIG_CLK_IN,
  input wire USER_CLOCK_SOURCE_IN,
  input wire EXTERNAL_DONE_INPUT_IN,
  input wire OSCILLATOR_CLOCK_INPUT_IN,
  // startup results
  output wire SET_RESET_RELEASE_OUT,
  output wire OUTPUT_RELEASE_OUT,
  output wire LENGTH_COUNT_METHOD_OUT,
  output wire OSC_CLK_OUT,
  output wire READBACK_ACTIVE_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // event helpers

  // which codes are offered for a clock source and sync setting
  function ev_allowed;
    input [3:0] code;
    input usr;
    input sync;
    begin
      case ({usr, sync})
        2'b01: ev_allowed = (code == `EV_C2) || (code == `EV_C3) || (code == `EV_DI) || (code == `EV_DI1);
        2'b00: ev_allowed = (code == `EV_C2) || (code == `EV_C3) || (code == `EV_C4);
        2'b11: ev_allowed = (code == `EV_U2) || (code == `EV_DI) || (code == `EV_DI1) || (code == `EV_DI2);
        2'b10: ev_allowed = (code == `EV_U2) || (code == `EV_U3) || (code == `EV_U4);
        default: ev_allowed = 1'b0;
      endcase
    end
  endfunction

  // keep an offered code, else the default, else U2, the second user edge
  function [3:0] ev_pick;
    input [3:0] code;
    input [3:0] dflt;
    input usr;
    input sync;
    begin
      if (ev_allowed(code, usr, sync)) begin
        ev_pick = code;
      end else if (ev_allowed(dflt, usr, sync)) begin
        ev_pick = dflt;
      end else begin
        ev_pick = `EV_U2;
      end
    end
  endfunction

  // has the chosen event been seen yet
  function ev_hit;
    input [3:0] code;
    input [2:0] ccnt;
    input [2:0] ucnt;
    input dseen;
    input [2:0] dcnt;
    begin
      case (code)
        `EV_C2: ev_hit = (ccnt >= 3'd2);
        `EV_C3: ev_hit = (ccnt >= 3'd3);
        `EV_C4: ev_hit = (ccnt >= 3'd4);
        `EV_U2: ev_hit = (ucnt >= 3'd2);
        `EV_U3: ev_hit = (ucnt >= 3'd3);
        `EV_U4: ev_hit = (ucnt >= 3'd4);
        `EV_DI: ev_hit = dseen;
        `EV_DI1: ev_hit = (dcnt >= 3'd1);
        `EV_DI2: ev_hit = (dcnt >= 3'd2);
        default: ev_hit = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin sampling

  wire [3:0] pin_level;
  wire [3:0] pin_rise;

  pin_sampler #(
    .WIDTH(4)
  ) u_pins (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .pin_in({OSCILLATOR_CLOCK_INPUT_IN, EXTERNAL_DONE_INPUT_IN, USER_CLOCK_SOURCE_IN, CONFIG_CLK_IN}),
    .level_out(pin_level),
    .rise_out(pin_rise)
  );

  wire cclk_rise = pin_rise[0];
  wire user_rise = pin_rise[1];
  wire done_level = pin_level[2];
  wire osc_user_level = pin_level[3];

  ////////////////////////////////////////////////////////////////////////
  // registers and decode

  reg [31:0] ctrl_ff;
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg [2:0] cclk_cnt_ff;
  reg [2:0] user_cnt_ff;
  reg [2:0] done_cnt_ff;
  reg done_seen_ff;
  reg set_reset_rel_ff;
  reg output_rel_ff;
  reg rb_active_ff;
  reg [15:0] rb_cnt_ff;
  reg osc_ff;
  reg [7:0] osc_div_ff;

  wire startup_clock_select = ctrl_ff[`CTRL_CLKSEL];
  wire done_sync_select = ctrl_ff[`CTRL_SYNC];
  wire length_count_method = ctrl_ff[`CTRL_LCMETH];
  wire oscillator_source_select = ctrl_ff[`CTRL_OSCSEL];
  wire readback_abort_enable = ctrl_ff[`CTRL_RBABORT];
  wire readback_enable = ctrl_ff[`CTRL_RBEN];
  wire [3:0] set_reset_release_event = ctrl_ff[`CTRL_GSR_LO+3:`CTRL_GSR_LO];
  wire [3:0] output_release_event = ctrl_ff[`CTRL_OUT_LO+3:`CTRL_OUT_LO];

  // effective choices follow clock source and sync live
  wire [3:0] gsr_eff = ev_pick(set_reset_release_event, `EV_GSR_DEFAULT,
    startup_clock_select, done_sync_select); // RULE1 RULE5 RULE8 RULE15
  wire [3:0] out_eff = ev_pick(output_release_event, `EV_OUT_DEFAULT,
    startup_clock_select, done_sync_select); // RULE6 RULE7 RULE8 RULE15

  wire [7:0] addr_lo = PADDR_IN[7:0];
  wire setup = PSEL_IN & ~PENABLE_IN;
  wire wr_commit = PSEL_IN & PENABLE_IN & pready_ff & PWRITE_IN;
  wire hit_ctrl = (addr_lo == `OFF_CTRL);
  wire hit_status = (addr_lo == `OFF_STATUS);
  wire hit_rb = (addr_lo == `OFF_RB_CMD);
  wire hit_eff = (addr_lo == `OFF_EFFECTIVE);
  wire mapped = hit_ctrl | hit_status | hit_rb | hit_eff;

  wire [31:0] status_word = {13'h0000, done_cnt_ff, 1'b0, user_cnt_ff, 1'b0, cclk_cnt_ff,
    3'h0, LENGTH_COUNT_MET_IN, done_seen_ff, rb_active_ff, output_rel_ff, set_reset_rel_ff};

  // read mux, sampled at the setup cycle
  reg [31:0] rd_mux;
  always @* begin
    case (addr_lo)
      `OFF_CTRL: rd_mux = ctrl_ff;
      `OFF_STATUS: rd_mux = status_word;
      `OFF_EFFECTIVE: rd_mux = {24'h000000, out_eff, gsr_eff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait-free access phase

  always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup && !PWRITE_IN) begin
        prdata_ff <= rd_mux;
      end else if (!PSEL_IN) begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // control register; status and effective words are read-only
  always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_ff <= `CTRL_RESET; // RULE1 RULE6 RULE9 RULE10 RULE11 RULE12 RULE13
    end else if (wr_commit && hit_ctrl) begin
      ctrl_ff <= PWDATA_IN & `CTRL_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // startup edge counting; everything idles until the count is met

  wire startup_rise = startup_clock_select ? user_rise : cclk_rise; // RULE13 RULE4

  always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cclk_cnt_ff <= 3'd0;
      user_cnt_ff <= 3'd0;
      done_cnt_ff <= 3'd0;
      done_seen_ff <= 1'b0;
    end else if (!LENGTH_COUNT_MET_IN) begin
      cclk_cnt_ff <= 3'd0;
      user_cnt_ff <= 3'd0;
      done_cnt_ff <= 3'd0;
      done_seen_ff <= 1'b0;
    end else begin
      // saturate so late events stay reached
      if (cclk_rise && cclk_cnt_ff != 3'd7) begin
        cclk_cnt_ff <= cclk_cnt_ff + 3'd1; // RULE2
      end
      // user edges only count once the first config edge is behind us
      if (user_rise && cclk_cnt_ff != 3'd0 && user_cnt_ff != 3'd7) begin
        user_cnt_ff <= user_cnt_ff + 3'd1; // RULE3
      end
      if (done_level) begin
        done_seen_ff <= 1'b1; // RULE4 RULE14
      end
      // edges counted strictly after done was seen high
      if (done_seen_ff && startup_rise && done_cnt_ff != 3'd7) begin
        done_cnt_ff <= done_cnt_ff + 3'd1; // RULE4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // release flags, sticky until the count drops

  wire gsr_hit = ev_hit(gsr_eff, cclk_cnt_ff, user_cnt_ff, done_seen_ff, done_cnt_ff);
  wire out_hit = ev_hit(out_eff, cclk_cnt_ff, user_cnt_ff, done_seen_ff, done_cnt_ff);

  always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      set_reset_rel_ff <= 1'b0;
      output_rel_ff <= 1'b0;
    end else begin
      set_reset_rel_ff <= LENGTH_COUNT_MET_IN & (set_reset_rel_ff | gsr_hit); // RULE1
      output_rel_ff <= LENGTH_COUNT_MET_IN & (output_rel_ff | out_hit); // RULE6 RULE14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readback sequence

  wire rb_start = wr_commit & hit_rb & PWDATA_IN[`RB_START];
  wire rb_abort = wr_commit & hit_rb & PWDATA_IN[`RB_ABORT];

  always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rb_active_ff <= 1'b0;
      rb_cnt_ff <= 16'h0000;
    end else if (rb_active_ff) begin
      // abort ignored unless enabled; otherwise run to the end
      if (rb_abort && readback_abort_enable) begin
        rb_active_ff <= 1'b0; // RULE11
        rb_cnt_ff <= 16'h0000;
      end else if (rb_cnt_ff == 16'h0000) begin
        rb_active_ff <= 1'b0;
      end else begin
        rb_cnt_ff <= rb_cnt_ff - 16'h0001;
      end
    end else if (rb_start && readback_enable) begin
      rb_active_ff <= 1'b1; // RULE12
      rb_cnt_ff <= RB_WORDS[15:0] - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator source: divided core clock or sampled user clock

  // terminal divider count, sized to the counter so the compare is width-clean
  localparam [7:0] OSC_LAST = `OSC_HALF_CYC - 1;

  always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_ff <= 1'b0;
      osc_div_ff <= 8'h00;
    end else if (oscillator_source_select) begin
      osc_ff <= osc_user_level; // RULE10
      osc_div_ff <= 8'h00;
    end else if (osc_div_ff == OSC_LAST) begin
      osc_ff <= ~osc_ff; // RULE10
      osc_div_ff <= 8'h00;
    end else begin
      osc_div_ff <= osc_div_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flop

  assign PRDATA_OUT = prdata_ff;
  assign PREADY_OUT = pready_ff;
  assign PSLVERR_OUT = pslverr_ff;
  assign SET_RESET_RELEASE_OUT = set_reset_rel_ff;
  assign OUTPUT_RELEASE_OUT = output_rel_ff;
  assign LENGTH_COUNT_METHOD_OUT = length_count_method; // RULE9
  assign OSC_CLK_OUT = osc_ff;
  assign READBACK_ACTIVE_OUT = rb_active_ff;

endmodule

// ---- tb/startup_seq_monitor.sv ----
`timescale 1ns/1ps
module startup_seq_monitor #(parameter ADDR_W = 8) (
  // clock, reset and apb
  input wire CORE_CLK_IN,
  input wire RST_N_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [ADDR_W-1:0] PADDR_IN,
  input wire PREADY_OUT,
  input wire PSLVERR_OUT,
  // startup
  input wire LENGTH_COUNT_MET_IN,
  input wire SET_RESET_RELEASE_OUT,
  input wire OUTPUT_RELEASE_OUT,
  input wire LENGTH_COUNT_METHOD_OUT,
  input wire READBACK_ACTIVE_OUT
);
  // committed writes; output registers may lag the commit by one cycle
  wire wr_ctrl = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN[7:0] == 8'h00;
  wire wr_cmd = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN[7:0] == 8'h08;
  // addresses outside the four words must answer with an error
  wire unmapped = PADDR_IN[7:0] != 8'h00 && PADDR_IN[7:0] != 8'h04 && PADDR_IN[7:0] != 8'h08
    && PADDR_IN[7:0] != 8'h0C;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_setup; PSEL_IN && !PENABLE_IN; endsequence
  sequence s_answer; PREADY_OUT ##1 !PREADY_OUT; endsequence
  property p_ready; s_setup |=> s_answer; endproperty
  property p_err; PSLVERR_OUT |-> PREADY_OUT; endproperty
  property p_err_map; PSEL_IN && !PENABLE_IN && unmapped |=> PSLVERR_OUT; endproperty
  property p_rb_cause; $rose(READBACK_ACTIVE_OUT) |-> $past(wr_cmd) || $past(wr_cmd, 2); endproperty
  property p_lcm; $changed(LENGTH_COUNT_METHOD_OUT) |-> $past(wr_ctrl) || $past(wr_ctrl, 2); endproperty
  property p_sr_cause; $rose(SET_RESET_RELEASE_OUT) |-> $past(LENGTH_COUNT_MET_IN, 2); endproperty
  property p_out_cause; $rose(OUTPUT_RELEASE_OUT) |-> $past(LENGTH_COUNT_MET_IN, 2); endproperty
  property p_sr_hold; SET_RESET_RELEASE_OUT && LENGTH_COUNT_MET_IN |=> SET_RESET_RELEASE_OUT; endproperty
  property p_out_hold; OUTPUT_RELEASE_OUT && LENGTH_COUNT_MET_IN |=> OUTPUT_RELEASE_OUT; endproperty
  property p_clear; !LENGTH_COUNT_MET_IN |-> ##2 !SET_RESET_RELEASE_OUT && !OUTPUT_RELEASE_OUT; endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_err_map: assert property (p_err_map) else $error("unmapped access without error");
  a_rb_cause: assert property (p_rb_cause) else $error("readback without command");
  a_lcm: assert property (p_lcm) else $error("method moved without write");
  a_sr_cause: assert property (p_sr_cause) else $error("set reset early");
  a_out_cause: assert property (p_out_cause) else $error("outputs early");
  a_sr_hold: assert property (p_sr_hold) else $error("set reset dropped");
  a_out_hold: assert property (p_out_hold) else $error("outputs dropped");
  a_clear: assert property (p_clear) else $error("release not cleared");
endmodule
bind startup_sequencer startup_seq_monitor #(.ADDR_W(ADDR_W)) mon (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .LENGTH_COUNT_MET_IN(LENGTH_COUNT_MET_IN), .SET_RESET_RELEASE_OUT(SET_RESET_RELEASE_OUT),
  .OUTPUT_RELEASE_OUT(OUTPUT_RELEASE_OUT), .LENGTH_COUNT_METHOD_OUT(LENGTH_COUNT_METHOD_OUT),
  .READBACK_ACTIVE_OUT(READBACK_ACTIVE_OUT));

// ---- tb/done_line_model.sv ----
`timescale 1ns/1ps
module done_line_model (
  // clock
  input wire clk_in,
  // other devices have finished
  input wire release_in,
  // shared done line
  output logic done_out
);
  // others hold the line low until all let go
  initial done_out = 1'b0;
  always @(posedge clk_in) begin
    done_out <= release_in;
  end
endmodule

// ---- tb/post_config_startup_sequencer_bench.sv ----
`timescale 1ns/1ps
module post_config_startup_sequencer_bench;
  logic clk, rst_n, psel, pen, pwr, lc, osc, dn_rel, err, ov;
  logic [1:0] clkp;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, sr, outr, lcm, oscq, rba, done;
  int n_mismatch = 0;
  int n_checks = 0;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  startup_sequencer #(.RB_WORDS(8)) dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .LENGTH_COUNT_MET_IN(lc), .CONFIG_CLK_IN(clkp[0]),
    .USER_CLOCK_SOURCE_IN(clkp[1]), .EXTERNAL_DONE_INPUT_IN(done), .OSCILLATOR_CLOCK_INPUT_IN(osc),
    .SET_RESET_RELEASE_OUT(sr), .OUTPUT_RELEASE_OUT(outr), .LENGTH_COUNT_METHOD_OUT(lcm),
    .OSC_CLK_OUT(oscq), .READBACK_ACTIVE_OUT(rba));
  done_line_model far (.clk_in(clk), .release_in(dn_rel), .done_out(done));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // pins pass synchronisers, so each high phase lasts six cycles and each low phase at least six
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      @(posedge clk);
      clkp[p] <= 1'b1;
      repeat (6) @(posedge clk);
      clkp[p] <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic rel(input logic o, input logic s);
    @(negedge clk);
    chk({30'h0, outr, sr}, {30'h0, o, s});
    @(posedge clk);
  endtask
  task automatic rbchk(input logic e);
    repeat (2) @(negedge clk);
    chk({31'h0, rba}, {31'h0, e});
    @(posedge clk);
  endtask
  // allowed set per {sync, user clock}; fallback is default, else user edge two
  function automatic logic [3:0] eff(input logic [3:0] c, input logic [3:0] df, input logic [1:0] m);
    logic [9:0] ok;
    ok = (m == 2'd0) ? 10'h00E : (m == 2'd1) ? 10'h070 : (m == 2'd2) ? 10'h186 : 10'h390;
    if (c <= 4'h9 && ok[c]) return c;
    return ok[df] ? df : 4'h4;
  endfunction
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, pen, pwr, lc, osc, dn_rel, clkp, paddr, pwdata} = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'h00, 32'h0000_1200);
    rdchk(8'h0C, 32'h0000_0012);
    rdchk(8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    // default walk on config clock edges
    lc <= 1'b1;
    pulse(0, 2);
    rel(1'b1, 1'b0);
    pulse(0, 1);
    rel(1'b1, 1'b1);
    rdchk(8'h04, 32'h0000_0313);
    lc <= 1'b0;
    repeat (3) @(posedge clk);
    rel(1'b0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 11; c++) begin
        wr(8'h00, {16'h0, c[3:0], c[3:0], 6'h0, m[1:0]});
        rdchk(8'h0C, {24'h0, eff(c[3:0], 4'h1, m[1:0]), eff(c[3:0], 4'h2, m[1:0])});
      end
    end
    // user clock: an edge before the first config edge must not count
    wr(8'h00, 32'h0000_4501);
    lc <= 1'b1;
    pulse(1, 1);
    pulse(0, 1);
    pulse(1, 2);
    rel(1'b1, 1'b0);
    pulse(1, 1);
    rel(1'b1, 1'b1);
    lc <= 1'b0;
    // done sync: nothing moves until the far side lets go
    wr(8'h00, 32'h0000_7802);
    lc <= 1'b1;
    pulse(0, 3);
    rel(1'b0, 1'b0);
    dn_rel <= 1'b1;
    repeat (8) @(posedge clk);
    rel(1'b1, 1'b0);
    pulse(0, 1);
    rel(1'b1, 1'b1);
    // internal source: find a toggle, then expect six cycles per half period
    @(negedge clk);
    ov = oscq;
    while (oscq === ov) @(negedge clk);
    ov = oscq;
    repeat (5) @(negedge clk);
    chk({31'h0, oscq}, {31'h0, ov});
    @(negedge clk);
    chk({31'h0, oscq}, {31'h0, ~ov});
    wr(8'h00, 32'h0000_120C);
    osc <= 1'b1;
    repeat (6) @(posedge clk);
    chk({30'h0, lcm, oscq}, 32'h3);
    osc <= 1'b0;
    repeat (6) @(posedge clk);
    chk({31'h0, oscq}, 32'h0);
    wr(8'h08, 32'h1);
    rbchk(1'b0);
    wr(8'h00, 32'h0000_1220);
    wr(8'h08, 32'h3);
    rbchk(1'b1);
    // abort while running but not enabled must be ignored
    wr(8'h08, 32'h2);
    rbchk(1'b1);
    repeat (7) @(posedge clk);
    rbchk(1'b0);
    wr(8'h00, 32'h0000_1230);
    wr(8'h08, 32'h1);
    wr(8'h08, 32'h2);
    rbchk(1'b0);
    complete_run();
  end
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
